// ==== common/idlctl_pkg.sv ====
// Notes on behaviour
// - Bit 7 set at sleep instruction shuts off the DMA/host port.
// - Bit 6 chooses whether the I/O-memory port stays active or sleeps.
// - Bit 5 chooses whether the external memory interface stays active or sleeps.
// - Bits 4 and 9 both set at sleep, with every companion bit set, stop the clock generator.
// - Bits 4 and 9 both clear keep the clock generator running.
// - Bit 4 set with bit 9 clear at sleep raises bus error.
// - Stopping the clock generator stops the system clock, deepest power state.
// - Bit 4 set with any companion bit clear at sleep raises bus error.
// - Bit 9 is the extended clock sleep bit, read/write, reset 0.
// - Bit 7 controls the DMA and host-port transaction port.
// - Bit 8 controls the instruction-fetch port for cache transactions.
// - Bit 0 controls the CPU domain across a sleep instruction.
package idlctl_pkg;
    // Register byte offsets on APB
    localparam logic [7:0]  IDLCTL_CFG_OFF    = 8'h00;
    localparam logic [7:0]  IDLCTL_STATE_OFF  = 8'h04;
    localparam logic [7:0]  IDLCTL_EVT_OFF    = 8'h08;
    localparam logic [7:0]  IDLCTL_MASK_OFF   = 8'h0C;
    localparam logic [7:0]  IDLCTL_WAKE_OFF   = 8'h10;
    // Bit positions of the configuration word
    localparam int IDLCTL_CPU_BIT   = 0;
    localparam int IDLCTL_MPI_BIT   = 1;
    localparam int IDLCTL_INSTRUCTION_CACHE_BIT = 2;
    localparam int IDLCTL_PER_BIT   = 3;
    localparam int IDLCTL_CLK_BIT   = 4;
    localparam int IDLCTL_EXTERNAL_MEMORY_INTERFACE_BIT  = 5;
    localparam int IDLCTL_IO_MEMORY_PORT_BIT = 6;
    localparam int IDLCTL_DMA_HOST_PORT_BIT = 7;
    localparam int IDLCTL_INSTR_FETCH_PORT_BIT = 8;
    localparam int IDLCTL_CLKE_BIT  = 9;
    // Reset values and writable bits
    localparam logic [15:0] IDLCTL_CFG_RST   = 16'h0000;
    localparam logic [15:0] IDLCTL_CFG_WMASK = 16'h03FF;
    localparam logic [1:0]  IDLCTL_EVT_RST   = 2'h0;
    // Companion bits that must be set for clock idle
    localparam logic [15:0] IDLCTL_CLK_REQ   = 16'h03E7;
    // Event bits
    localparam int IDLCTL_EV_BUSERR = 0;
    localparam int IDLCTL_EV_SLEEP  = 1;
    // Per-domain shut-off outputs
    typedef struct packed {
        logic clock_gen;
        logic instr_fetch_port;
        logic dma_host_port;
        logic io_memory_port;
        logic external_memory_interface;
        logic peripherals;
        logic instruction_cache;
        logic master_periph;
        logic processor;
    } idlctl_domains_t;
endpackage

// ==== hdl/idlctl_top.sv ====
// The implementer's own choices: the APB slave port and the placing of the registers.
`timescale 1ns/1ps
module idlctl_top
    import idlctl_pkg::*;
(
    // Clock and reset
    input  wire logic        REF_CLK,
    input  wire logic        RST,
    // APB slave
    input  wire logic        PSEL,
    input  wire logic        PENABLE,
    input  wire logic        PWRITE,
    input  wire logic [7:0]  PADDR,
    input  wire logic [31:0] PWDATA,
    output logic      [31:0] PRDATA,
    output logic             PREADY,
    output logic             PSLVERR,
    // CPU sleep instruction strobe
    input  wire logic        SLEEP_EXEC,
    // Domain shut-off levels
    output idlctl_domains_t  DOMAIN_OFF,
    // Interrupts
    output logic             BUS_ERR_IRQ,
    output logic             IRQ
);
    logic [15:0]     cfg;
    logic [1:0]      evt;
    logic [1:0]      mask;
    idlctl_domains_t off;
    logic [31:0]     rdata;

    // APB decode
    wire acc       = PSEL && PENABLE;
    wire wr        = acc && PWRITE;
    wire hit_cfg   = PADDR == IDLCTL_CFG_OFF;
    wire hit_state = PADDR == IDLCTL_STATE_OFF;
    wire hit_evt   = PADDR == IDLCTL_EVT_OFF;
    wire hit_mask  = PADDR == IDLCTL_MASK_OFF;
    wire hit_wake  = PADDR == IDLCTL_WAKE_OFF;
    wire mapped    = hit_cfg | hit_state | hit_evt | hit_mask | hit_wake;

    // Clock idle validity checks
    wire clk_req  = cfg[IDLCTL_CLK_BIT];
    wire clke_ok  = cfg[IDLCTL_CLKE_BIT];
    wire comp_ok  = (cfg & IDLCTL_CLK_REQ) == IDLCTL_CLK_REQ;
    wire bad_idle = SLEEP_EXEC && clk_req && !(clke_ok && comp_ok);
    wire good     = SLEEP_EXEC && !bad_idle;
    wire clk_stop = clk_req && clke_ok;

    // Domain states captured at the sleep instruction
    idlctl_domains_t next_off;
    assign next_off = '{
        clock_gen:                 clk_stop,
        instr_fetch_port:          cfg[IDLCTL_INSTR_FETCH_PORT_BIT],
        dma_host_port:             cfg[IDLCTL_DMA_HOST_PORT_BIT],
        io_memory_port:            cfg[IDLCTL_IO_MEMORY_PORT_BIT],
        external_memory_interface: cfg[IDLCTL_EXTERNAL_MEMORY_INTERFACE_BIT],
        peripherals:               cfg[IDLCTL_PER_BIT],
        instruction_cache:         cfg[IDLCTL_INSTRUCTION_CACHE_BIT],
        master_periph:             cfg[IDLCTL_MPI_BIT],
        processor:                 cfg[IDLCTL_CPU_BIT]
    };

    // Event set bits; set wins over write-one clear
    wire [1:0] ev_set = {good, bad_idle};
    wire [1:0] ev_clr = (wr && hit_evt) ? PWDATA[1:0] : 2'h0;

    // Read mux
    assign rdata = hit_cfg   ? {16'h0000, cfg} :
                   hit_state ? {23'h00_0000, off} :
                   hit_evt   ? {30'h0000_0000, evt} :
                   hit_mask  ? {30'h0000_0000, mask} : 32'h0000_0000;

    // Configuration register
    always_ff @(posedge REF_CLK or posedge RST) begin
        if (RST) begin
            cfg <= IDLCTL_CFG_RST;
        end else if (wr && hit_cfg) begin
            cfg <= PWDATA[15:0] & IDLCTL_CFG_WMASK;
        end
    end

    // Domain state changes only on a sleep instruction or wake write
    always_ff @(posedge REF_CLK or posedge RST) begin
        if (RST) begin
            off <= '0;
        end else if (good) begin
            off <= next_off;
        end else if (wr && hit_wake && PWDATA[0]) begin
            off <= '0;
        end
    end

    // Sticky events and mask
    always_ff @(posedge REF_CLK or posedge RST) begin
        if (RST) begin
            evt  <= IDLCTL_EVT_RST;
            mask <= IDLCTL_EVT_RST;
        end else begin
            evt <= (evt & ~ev_clr) | ev_set;
            if (wr && hit_mask) begin
                mask <= PWDATA[1:0];
            end
        end
    end

    // Read data register
    always_ff @(posedge REF_CLK or posedge RST) begin
        if (RST) begin
            PRDATA <= 32'h0000_0000;
        end else if (PSEL && !PENABLE && !PWRITE) begin
            PRDATA <= rdata;
        end
    end

    assign PREADY      = 1'b1;
    assign PSLVERR     = acc && !mapped;
    assign DOMAIN_OFF  = off;
    assign BUS_ERR_IRQ = evt[IDLCTL_EV_BUSERR] && mask[IDLCTL_EV_BUSERR];
    assign IRQ         = |(evt & mask);

    // Checks on the sleep capture, event logic and register port.
    // All of them run on the one clock and stay quiet during reset.

    // An invalid clock idle always leaves a bus error behind
    chk_bad_sets_err: assert property (
        @(posedge REF_CLK) disable iff (RST)
        bad_idle |=> evt[IDLCTL_EV_BUSERR])
        else $error("bus error event missing");

    // An invalid clock idle must not move any domain
    chk_bad_keeps_dom: assert property (
        @(posedge REF_CLK) disable iff (RST)
        bad_idle |=> $stable(off))
        else $error("bad idle changed domains");

    // Without a sleep or a wake write the domains hold
    chk_no_sleep_hold: assert property (
        @(posedge REF_CLK) disable iff (RST)
        (!SLEEP_EXEC && !(wr && hit_wake)) |=> $stable(off))
        else $error("domains moved without sleep");

    // Clock off implies the cpu and dma port are off too
    chk_clk_pair: assert property (
        @(posedge REF_CLK) disable iff (RST)
        off.clock_gen |-> off.processor && off.dma_host_port)
        else $error("clock off without companions");

    // Clock bit clear keeps the generator running
    chk_clk_run: assert property (
        @(posedge REF_CLK) disable iff (RST)
        (good && !clk_req) |=> !off.clock_gen)
        else $error("clock stopped with bits clear");

    // Extended clock bit clear also keeps it running
    chk_clk_run_ext: assert property (
        @(posedge REF_CLK) disable iff (RST)
        (good && !clke_ok) |=> !off.clock_gen)
        else $error("clock stopped without extended bit");

    // Both clock bits set on a valid sleep stop the clock
    chk_clk_stop_ok: assert property (
        @(posedge REF_CLK) disable iff (RST)
        (good && clk_stop) |=> off.clock_gen)
        else $error("clock generator not stopped");

    // A stopped clock has the other five companion domains off
    chk_clk_full_set: assert property (
        @(posedge REF_CLK) disable iff (RST)
        off.clock_gen |-> off.instr_fetch_port && off.io_memory_port
            && off.external_memory_interface && off.instruction_cache
            && off.master_periph)
        else $error("clock off with a companion awake");

    // Clock bit without extended bit raises the error
    chk_clke_miss_err: assert property (
        @(posedge REF_CLK) disable iff (RST)
        (SLEEP_EXEC && clk_req && !clke_ok) |=> evt[IDLCTL_EV_BUSERR])
        else $error("missing extended bit not flagged");

    // Clock bit with a companion clear raises the error
    chk_comp_miss_err: assert property (
        @(posedge REF_CLK) disable iff (RST)
        (SLEEP_EXEC && clk_req && !comp_ok) |=> evt[IDLCTL_EV_BUSERR])
        else $error("missing companion not flagged");

    // Dma and host port follows its sleep bit
    chk_dma_host_port_cap: assert property (
        @(posedge REF_CLK) disable iff (RST)
        good |=> off.dma_host_port == $past(cfg[IDLCTL_DMA_HOST_PORT_BIT]))
        else $error("dma host port state wrong");

    // Io memory port follows its sleep bit
    chk_io_memory_port_cap: assert property (
        @(posedge REF_CLK) disable iff (RST)
        good |=> off.io_memory_port == $past(cfg[IDLCTL_IO_MEMORY_PORT_BIT]))
        else $error("io memory port state wrong");

    // External memory interface follows its sleep bit
    chk_external_memory_interface_cap: assert property (
        @(posedge REF_CLK) disable iff (RST)
        good |=> off.external_memory_interface
                 == $past(cfg[IDLCTL_EXTERNAL_MEMORY_INTERFACE_BIT]))
        else $error("memory interface state wrong");

    // Fetch port and cpu follow their sleep bits
    chk_instr_fetch_port_cpu: assert property (
        @(posedge REF_CLK) disable iff (RST)
        good |=> off.instr_fetch_port == $past(cfg[IDLCTL_INSTR_FETCH_PORT_BIT])
              && off.processor == $past(cfg[IDLCTL_CPU_BIT]))
        else $error("fetch port or cpu state wrong");

    // Master peripheral, cache and peripherals follow their bits
    chk_misc_cap: assert property (
        @(posedge REF_CLK) disable iff (RST)
        good |=> off.master_periph == $past(cfg[IDLCTL_MPI_BIT])
              && off.instruction_cache == $past(cfg[IDLCTL_INSTRUCTION_CACHE_BIT])
              && off.peripherals == $past(cfg[IDLCTL_PER_BIT]))
        else $error("minor domain state wrong");

    // A valid sleep records the sleep event
    chk_sleep_event: assert property (
        @(posedge REF_CLK) disable iff (RST)
        good |=> evt[IDLCTL_EV_SLEEP])
        else $error("sleep event missing");

    // Wake write without a sleep clears every domain
    chk_wake_clears: assert property (
        @(posedge REF_CLK) disable iff (RST)
        (wr && hit_wake && PWDATA[0] && !good) |=> (off == '0))
        else $error("wake write left a domain off");

    // Configuration write stores the writable bits only
    chk_cfg_write: assert property (
        @(posedge REF_CLK) disable iff (RST)
        (wr && hit_cfg) |=>
            (cfg == ($past(PWDATA[15:0]) & IDLCTL_CFG_WMASK)))
        else $error("configuration write wrong");

    // Configuration holds when it is not written
    chk_cfg_hold: assert property (
        @(posedge REF_CLK) disable iff (RST)
        !(wr && hit_cfg) |=> $stable(cfg))
        else $error("configuration changed unwritten");

    // Mask holds when it is not written
    chk_mask_hold: assert property (
        @(posedge REF_CLK) disable iff (RST)
        !(wr && hit_mask) |=> $stable(mask))
        else $error("mask changed unwritten");

    // Write one clears the bus error unless a new one comes
    chk_evt_clear: assert property (
        @(posedge REF_CLK) disable iff (RST)
        (wr && hit_evt && PWDATA[0] && !bad_idle)
            |=> !evt[IDLCTL_EV_BUSERR])
        else $error("bus error event not cleared");

    // Read data is loaded in the setup cycle of a read
    chk_read_load: assert property (
        @(posedge REF_CLK) disable iff (RST)
        (PSEL && !PENABLE && !PWRITE) |=> (PRDATA == $past(rdata)))
        else $error("read data not loaded");

    // Zero wait states on the register port
    chk_ready_high: assert property (
        @(posedge REF_CLK) disable iff (RST)
        acc |-> PREADY)
        else $error("ready low in access phase");

    // Unmapped access answers with an error
    chk_slverr_map: assert property (
        @(posedge REF_CLK) disable iff (RST)
        acc |-> (PSLVERR == !mapped))
        else $error("slave error wrong");

    // Unmasked bus error event drives the interrupt
    chk_irq_level: assert property (
        @(posedge REF_CLK) disable iff (RST)
        (evt[0] && mask[0]) |-> IRQ)
        else $error("interrupt not raised");

    // No unmasked event leaves the interrupt low
    chk_irq_low: assert property (
        @(posedge REF_CLK) disable iff (RST)
        !(|(evt & mask)) |-> !IRQ)
        else $error("interrupt raised without event");

    // Bus error interrupt is part of the summary line
    chk_berr_irq: assert property (
        @(posedge REF_CLK) disable iff (RST)
        BUS_ERR_IRQ |-> IRQ)
        else $error("bus error not on summary");
endmodule

// ==== verification/idlctl_cpu_model.sv ====
`timescale 1ns/1ps
module idlctl_cpu_model (
    // Clock
    input  wire logic clk,
    // Sleep instruction strobe
    output logic      sleep_exec
);
    initial sleep_exec = 1'b0;
    // One sleep instruction, one cycle long, launched after an edge
    task automatic pulse();
        @(posedge clk);
        sleep_exec <= 1'b1;
        @(posedge clk);
        sleep_exec <= 1'b0;
    endtask
endmodule

// ==== verification/idlctl_top_tb_top.sv ====
`timescale 1ns/1ps
module idlctl_top_tb_top;
    import idlctl_pkg::*;
    logic            clk = 0, rst = 1, psel = 0, pen = 0, pwr = 0, err;
    logic [7:0]      padr = 0;
    logic [31:0]     pwd = 0, prd, rd;
    logic            prdy, perr, slp, berr, irq;
    idlctl_domains_t dom_off;
    logic [8:0]      dom = 0;
    int              fails = 0, samples_checked = 0;
    always #2 clk = ~clk;
    idlctl_cpu_model i_idlctl_cpu_model (.clk(clk), .sleep_exec(slp));
    idlctl_top i_idlctl_top (.REF_CLK(clk), .RST(rst), .PSEL(psel),
        .PENABLE(pen), .PWRITE(pwr), .PADDR(padr), .PWDATA(pwd),
        .PRDATA(prd), .PREADY(prdy), .PSLVERR(perr), .SLEEP_EXEC(slp),
        .DOMAIN_OFF(dom_off), .BUS_ERR_IRQ(berr), .IRQ(irq));
    // Compare and count
    task automatic chk(string nm, logic [31:0] seen, logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            fails++;
            $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    // APB transfer, held until pready is seen high
    task automatic apb(logic w, logic [7:0] a, logic [31:0] d);
        int n;
        n = 0;
        @(posedge clk);
        psel <= 1'b1;
        pwr <= w;
        padr <= a;
        pwd <= d;
        @(posedge clk);
        pen <= 1'b1;
        do begin
            @(posedge clk);
            n++;
        end while (prdy !== 1'b1 && n < 50);
        if (n >= 50) fails++;
        rd = prd;
        err = perr;
        psel <= 1'b0;
        pen <= 1'b0;
    endtask
    // Program, check nothing moves, sleep, check domains and events
    task automatic t_sleep(logic [15:0] c, logic [8:0] d, logic [1:0] e);
        apb(1, IDLCTL_CFG_OFF, {16'h0000, c});
        apb(0, IDLCTL_CFG_OFF, 0);
        chk("cfg", rd, {16'h0000, c});
        chk("hold", dom_off, dom);
        i_idlctl_cpu_model.pulse();
        @(negedge clk);
        chk("domains", dom_off, d);
        dom = d;
        apb(0, IDLCTL_EVT_OFF, 0);
        chk("events", rd, e);
        chk("irq", {berr, irq}, {2{e[0]}});
        apb(1, IDLCTL_EVT_OFF, 3);
        @(negedge clk);
        chk("irq clear", irq, 1'b0);
    endtask
    task automatic end_of_test();
        if (fails == 0 && samples_checked > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    initial begin
        repeat (20) @(posedge clk);
        rst <= 1'b0;
        apb(0, IDLCTL_CFG_OFF, 0);
        chk("cfg reset", rd, 0);
        apb(1, IDLCTL_MASK_OFF, 1);
        t_sleep(16'h00E0, 9'h070, 2'b10);
        t_sleep(16'h0181, 9'h0C1, 2'b10);
        t_sleep(16'h0000, 9'h000, 2'b10);
        t_sleep(16'h03F7, 9'h1F7, 2'b10);
        t_sleep(16'h01F7, 9'h1F7, 2'b01);
        t_sleep(16'h0217, 9'h1F7, 2'b01);
        apb(1, IDLCTL_WAKE_OFF, 1);
        apb(0, IDLCTL_STATE_OFF, 0);
        chk("wake", rd, 0);
        apb(1, 8'h20, 32'hFFFF_FFFF);
        chk("unmapped", err, 1'b1);
        apb(0, IDLCTL_CFG_OFF, 0);
        chk("cfg kept", rd, 32'h0000_0217);
        end_of_test();
    end
    // Watchdog
    initial begin
        repeat (5000) @(posedge clk);
        fails++;
        end_of_test();
    end
endmodule
